// [core_store_pkg.sv]
// Purpose: Shared constants and types for the core storage subsystem
// Assumes: 100 MHz clock, odd parity per half-word
// Notes: Stored word is two parity bits above 30 data bits
package core_store_pkg;

	// Address layout
	localparam int ADDR_W = 17;
	localparam int MOD_ADDR_W = 15;
	localparam int BANK_BIT = 16;
	localparam int STRAIGHT_MOD_BIT = 15;
	localparam int INTERLEAVE_MOD_BIT = 0;
	localparam int NUM_BANKS = 2;
	localparam int MODS_PER_BANK = 2;
	localparam int NUM_MODS = NUM_BANKS * MODS_PER_BANK;
	localparam int MOD_WORDS = 32768;

	// Data layout
	localparam int DATA_W = 30;
	localparam int HALF_W = 15;
	localparam int STORE_W = 32;
	localparam int PAR_UP_BIT = 31;
	localparam int PAR_LO_BIT = 30;
	localparam logic PARITY_ODD = 1'h1;
	localparam logic [29:0] FULL_MASK = 30'h3FFFFFFF;
	localparam logic [29:0] UPPER_MASK = 30'h3FFF8000;
	localparam logic [29:0] LOWER_MASK = 30'h00007FFF;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CYCLE_NS = 750;
	localparam int CYCLE_CYC_RAW = CYCLE_NS / CLK_PERIOD_NS;
	localparam int CYCLE_CYC = (CYCLE_CYC_RAW < 1) ? 1 : CYCLE_CYC_RAW;
	localparam int CNT_W = 8;

	// Reference size
	typedef enum logic [1:0] {
		SZ_WHOLE = 2'h0,
		SZ_UPPER = 2'h1,
		SZ_LOWER = 2'h2,
		SZ_BITS = 2'h3
	} size_t;

	// Module engine states
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_READ = 2'h1,
		ST_FETCH = 2'h2,
		ST_HOLD = 2'h3
	} eng_state_t;

endpackage

// [core_store_array.sv]
// Purpose: One storage module's word array, single port, registered read
// Assumes: Read data valid the cycle after a read strobe
// Notes: Write does not update read data
`timescale 1ns/1ps
module core_store_array #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32768,
	parameter int AW = 15
) (
	// Clock
	input wire logic clk,
	// Access port
	input wire logic en,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Single port; the engine never reads and writes in one cycle
	always_ff @(posedge clk) begin
		if (en && we) begin
			mem[addr] <= wdata;
		end
		if (en && !we) begin
			rdata <= mem[addr];
		end
	end

endmodule

// [core_store.sv]
// Overview of operation
// [RQ1] Module holds 32768 30-bit words, 15-bit address
// [RQ2] Processor presents 17-bit address each reference
// [RQ3] Interleaved: bit 0 module, bit 16 bank
// [RQ4] Straight: bit 16 bank, bit 15 module
// [RQ5] Remaining bits load module address register
// [RQ6] Manual switch selects straight addressing mode
// [RQ7] Two parity bits, one per half-word
// [RQ8] Whole, half and bit-masked word transfers
// [RQ9] Check parity on read, generate on write
// [RQ10] Parity mismatch raises parity interrupt
// [RQ11] Faulty word rewritten unchanged after read
// [RQ12] Grant request, then take address and access
// [RQ13] Acknowledge when the reference completes
// [RQ14] Bank is two independent, concurrently cycling modules
// [RQ15] One or two banks configured
// [RQ16] Read/restore cycle within 750 ns
// [RQ17] Module address from bits 15:1 or 14:0
// [RQ18] Only selected module responds; others stay free
//
// Purpose: Primary storage: module select, four module engines, parity
// Assumes: Request fields held stable from REQ until GRANT
// Notes: Double words are two whole-word references; interleaved they overlap
//        Parity alarm and acknowledge are one-cycle pulses, one per module
`timescale 1ns/1ps
module core_store
	import core_store_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Manual switches (asynchronous)
	input wire logic STRAIGHT_MODE,
	input wire logic TWO_BANKS,
	// Request from processor
	input wire logic REQ,
	input wire logic [core_store_pkg::ADDR_W-1:0] ADDR,
	input wire logic WRITE,
	input wire core_store_pkg::size_t SIZE,
	input wire logic [core_store_pkg::DATA_W-1:0] WMASK,
	input wire logic [core_store_pkg::DATA_W-1:0] WDATA,
	// Answers to processor
	output logic GRANT,
	output logic [core_store_pkg::NUM_MODS-1:0] ACK,
	output logic [core_store_pkg::NUM_MODS*core_store_pkg::DATA_W-1:0] RDATA,
	output logic [core_store_pkg::NUM_MODS-1:0] PARITY_INT
);

	// Switch synchronisers
	logic straight_m_q;
	logic straight_q;
	logic two_m_q;
	logic two_q;
	logic straight_m_d;
	logic straight_d;
	logic two_m_d;
	logic two_d;

	// Request decode
	logic sel_bank;
	logic sel_mod;
	logic [1:0] tgt;
	logic [MOD_ADDR_W-1:0] req_mod_addr;
	logic [DATA_W-1:0] req_mask;
	logic bank_ok;
	logic take;
	logic grant_d;
	logic grant_q;
	logic [NUM_MODS-1:0] idle_vec;

	// Switches are front-panel levels, so two flops before use
	// A switch moved while modules are busy only remaps later requests;
	// words already stored do not move, so software must reload after a change
	always_comb begin
		straight_m_d = STRAIGHT_MODE;
		straight_d = straight_m_q;
		two_m_d = TWO_BANKS;
		two_d = two_m_q;
	end

	// Reset forces interleaved addressing with a single bank
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			straight_m_q <= 1'h0;
			straight_q <= 1'h0;
			two_m_q <= 1'h0;
			two_q <= 1'h0;
		end else begin
			straight_m_q <= straight_m_d;
			straight_q <= straight_d; // [RQ6]
			two_m_q <= two_m_d;
			two_q <= two_d;
		end
	end

	// Bank and module select plus module address split
	// The two select bits are dropped from the module address, so each module
	// sees a dense 15-bit range whatever the mode
	always_comb begin
		sel_bank = ADDR[BANK_BIT]; // [RQ3] [RQ4]
		if (straight_q) begin
			sel_mod = ADDR[STRAIGHT_MOD_BIT]; // [RQ4]
			req_mod_addr = ADDR[MOD_ADDR_W-1:0]; // [RQ17] [RQ5]
		end else begin
			sel_mod = ADDR[INTERLEAVE_MOD_BIT]; // [RQ3]
			req_mod_addr = ADDR[MOD_ADDR_W:1]; // [RQ17] [RQ5]
		end
		tgt = {sel_bank, sel_mod};
	end

	// Write mask from reference size
	// Half-word sizes ignore WMASK; reads use the mask to pick the halves to check
	always_comb begin
		unique case (SIZE)
			SZ_WHOLE: req_mask = FULL_MASK; // [RQ8]
			SZ_UPPER: req_mask = UPPER_MASK; // [RQ8]
			SZ_LOWER: req_mask = LOWER_MASK; // [RQ8]
			SZ_BITS: req_mask = WMASK; // [RQ8]
		endcase
	end

	// Grant only when the bank exists and the chosen module is free
	// A refused request is not an error: it waits with REQ held, so a missing
	// bank stalls the processor until the switch brings the bank in
	always_comb begin
		bank_ok = !sel_bank || two_q; // [RQ15]
		take = REQ && bank_ok && idle_vec[tgt]; // [RQ12] [RQ18]
		grant_d = take;
	end

	// Registered so the grant is a clean one-cycle pulse
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			grant_q <= 1'h0;
		end else begin
			grant_q <= grant_d; // [RQ12]
		end
	end

	// Grant output straight from its flop
	assign GRANT = grant_q;

	// Odd parity over one half-word
	// Each half together with its parity bit holds an odd count of ones
	function automatic logic half_par(input logic [HALF_W-1:0] h);
		half_par = (^h) ^ PARITY_ODD;
	endfunction

	// Cycle plan of one reference, counted from the cycle in which GRANT is high:
	//   +0   array read strobe, address already latched
	//   +1   check or merge, then write back, since a core read destroys the word
	//   +2   read data and any parity alarm appear
	//   +2..+74 busy in hold, counting out the core cycle
	//   +75  acknowledge pulse; the module takes a new request from here
	// Trade-off: busy time is fixed, so a write costs as long as a read
	// One engine per module; each cycles on its own so two can overlap
	genvar m;
	generate
		for (m = 0; m < NUM_MODS; m++) begin : g_mod // [RQ14]
			eng_state_t st_q;
			eng_state_t st_d;
			logic [MOD_ADDR_W-1:0] addr_q;
			logic [MOD_ADDR_W-1:0] addr_d;
			logic wr_q;
			logic wr_d;
			logic [DATA_W-1:0] mask_q;
			logic [DATA_W-1:0] mask_d;
			logic [DATA_W-1:0] wdat_q;
			logic [DATA_W-1:0] wdat_d;
			logic [CNT_W-1:0] cnt_q;
			logic [CNT_W-1:0] cnt_d;
			logic [DATA_W-1:0] rdat_q;
			logic [DATA_W-1:0] rdat_d;
			logic ack_q;
			logic ack_d;
			logic perr_q;
			logic perr_d;
			logic mem_en;
			logic mem_we;
			logic [STORE_W-1:0] mem_wdata;
			logic [STORE_W-1:0] mem_rdata;
			logic [DATA_W-1:0] merged;
			logic bad_up;
			logic bad_lo;

			core_store_array #(
				.WIDTH(STORE_W),
				.DEPTH(MOD_WORDS),
				.AW(MOD_ADDR_W)
			) u_array (
				.clk(CLK),
				.en(mem_en),
				.we(mem_we),
				.addr(addr_q),
				.wdata(mem_wdata),
				.rdata(mem_rdata)
			); // [RQ1]

			// Sequence: take address, read, check and restore, wait out the cycle
			always_comb begin
				st_d = st_q;
				addr_d = addr_q;
				wr_d = wr_q;
				mask_d = mask_q;
				wdat_d = wdat_q;
				cnt_d = cnt_q;
				rdat_d = rdat_q;
				ack_d = 1'h0;
				perr_d = 1'h0;
				mem_en = 1'h0;
				mem_we = 1'h0;
				bad_up = 1'h0;
				bad_lo = 1'h0;
				merged = (mem_rdata[DATA_W-1:0] & ~mask_q) | (wdat_q & mask_q);
				mem_wdata = mem_rdata;
				unique case (st_q)
					ST_IDLE: begin
						// Only the addressed engine latches the request
						if (take && (tgt == 2'(m))) begin // [RQ18]
							st_d = ST_READ;
							addr_d = req_mod_addr; // [RQ5] [RQ12]
							wr_d = WRITE;
							mask_d = req_mask;
							wdat_d = WDATA;
							// Counter restarts so every reference gets the same busy time
							cnt_d = '0;
						end
					end
					ST_READ: begin
						// Array read; the data come back registered next cycle
						mem_en = 1'h1;
						cnt_d = cnt_q + 1'h1;
						st_d = ST_FETCH;
					end
					ST_FETCH: begin
						// Core reads are destructive, so every access ends in a write
						mem_en = 1'h1;
						mem_we = 1'h1;
						cnt_d = cnt_q + 1'h1;
						st_d = ST_HOLD;
						if (wr_q) begin
							// Fresh parity for both halves, whatever the write mask
							mem_wdata = {half_par(merged[DATA_W-1:HALF_W]),
								half_par(merged[HALF_W-1:0]), merged}; // [RQ7] [RQ9]
						end else begin
							// Only halves that the reference touches can raise the alarm
							bad_up = (|mask_q[DATA_W-1:HALF_W]) &&
								(half_par(mem_rdata[DATA_W-1:HALF_W]) !=
								mem_rdata[PAR_UP_BIT]); // [RQ9]
							bad_lo = (|mask_q[HALF_W-1:0]) &&
								(half_par(mem_rdata[HALF_W-1:0]) !=
								mem_rdata[PAR_LO_BIT]); // [RQ9]
							perr_d = bad_up || bad_lo; // [RQ10]
							// Faulty word goes back raw so it can be found again
							mem_wdata = mem_rdata; // [RQ11]
							rdat_d = mem_rdata[DATA_W-1:0];
						end
					end
					ST_HOLD: begin
						// Hold the module busy for the full core cycle
						// Count reaches its end one cycle before the acknowledge flop
						if (cnt_q >= CNT_W'(CYCLE_CYC - 1)) begin // [RQ16]
							st_d = ST_IDLE;
							ack_d = 1'h1; // [RQ13]
						end else begin
							cnt_d = cnt_q + 1'h1;
						end
					end
				endcase
			end

			// Engine registers; reset parks the module idle with no pulse pending
			always_ff @(posedge CLK) begin
				if (!NRST) begin
					st_q <= ST_IDLE;
					addr_q <= '0;
					wr_q <= 1'h0;
					mask_q <= '0;
					wdat_q <= '0;
					cnt_q <= '0;
					rdat_q <= '0;
					ack_q <= 1'h0;
					perr_q <= 1'h0;
				end else begin
					st_q <= st_d;
					addr_q <= addr_d;
					wr_q <= wr_d;
					mask_q <= mask_d;
					wdat_q <= wdat_d;
					cnt_q <= cnt_d;
					rdat_q <= rdat_d;
					ack_q <= ack_d; // [RQ13]
					perr_q <= perr_d; // [RQ10]
				end
			end

			// Answers come straight from the engine flops
			// RDATA keeps the last word read until the same module reads again
			assign idle_vec[m] = (st_q == ST_IDLE);
			assign ACK[m] = ack_q;
			assign PARITY_INT[m] = perr_q;
			assign RDATA[m*DATA_W +: DATA_W] = rdat_q;
		end
	endgenerate

endmodule

// [core_store_asserts.sv]
// Purpose: Port timing checks for core_store
// Assumes: One clock, synchronous reset
// Notes: Switches pass a two-flop sync
`timescale 1ns/1ps
module core_store_asserts (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Watched ports
	input wire logic TWO_BANKS,
	input wire logic REQ,
	input wire logic [16:0] ADDR,
	input wire logic GRANT,
	input wire logic [3:0] ACK,
	input wire logic [119:0] RDATA,
	input wire logic [3:0] PARITY_INT
);
	// One domain, so clock and reset are set once
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	AST_GRANT_PULSE: assert property (GRANT && $stable(ADDR) |=> !GRANT)
		else $error("long grant");
	AST_GRANT_CAUSE: assert property (GRANT |-> $past(REQ))
		else $error("grant without request");
	AST_BANK_ABSENT: assert property (GRANT && $past(ADDR[16]) |-> $past(TWO_BANKS, 3))
		else $error("absent bank granted");
	AST_ACK_DUE: assert property (GRANT |-> ##75 ACK != 4'h0)
		else $error("ack missing");
	AST_ACK_CAUSE: assert property (ACK != 4'h0 |-> $past(GRANT, 75))
		else $error("ack off time");
	AST_PAR_TIME: assert property (PARITY_INT != 4'h0 |-> $past(GRANT, 2))
		else $error("parity pulse off time");
	AST_RDATA_TIME: assert property ($changed(RDATA) |-> $past(GRANT, 2))
		else $error("read data off time");
	AST_RESET_QUIET: assert property ($rose(NRST) |-> !GRANT && ACK == 4'h0)
		else $error("output after reset");
endmodule
bind core_store core_store_asserts i_chk (.CLK, .NRST, .TWO_BANKS, .REQ, .ADDR, .GRANT, .ACK,
	.RDATA, .PARITY_INT);

// [cpu_port_model.sv]
// Purpose: Processor storage port model
// Assumes: Fields packed as one vector
// Notes: Released fields are inverted, never left stale
`timescale 1ns/1ps
module cpu_port_model (
	// Bench side
	input wire logic clk,
	input wire logic go,
	input wire logic [79:0] f,
	// Storage side
	input wire logic grant,
	output logic req = 1'h0,
	output logic [79:0] q = '0
);
	// Hold request and fields until grant is seen
	always @(posedge clk) begin
		if (go) begin
			req <= 1'h1;
			q <= f;
		end else if (grant) begin
			req <= 1'h0;
			q <= ~q;
		end
	end
endmodule

// [core_store_test.sv]
// Purpose: Self-checking bench for core_store
// Assumes: Processor side is cpu_port_model
// Notes: Parity faults cannot be made from the ports
`timescale 1ns/1ps
module core_store_test;
	import core_store_pkg::*;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic straight = 1'h0;
	logic two_banks = 1'h0;
	logic go = 1'h0;
	logic req, grant, wr;
	logic [1:0] sz;
	logic [16:0] addr;
	logic [29:0] wmask, wdata, e;
	logic [3:0] ack, par;
	logic [119:0] rdata;
	logic [79:0] fld = '0;
	logic [79:0] q;
	int n_errors = 0, checks_done = 0, cyc = 0, npar = 0, t_g, ta, tb;
	// Rows: straight, address, module index
	logic [19:0] rows [8] = '{20'h00000, 20'h00005, 20'h4000A, 20'h7FFFF, 20'hA0001, 20'hC0006,
		20'hDFFFE, 20'hE0017};
	logic [29:0] mk [4] = '{FULL_MASK, UPPER_MASK, LOWER_MASK, 30'h0000FFF0};
	logic [29:0] dv [4] = '{30'h2AAAAAAA, 30'h15555555, 30'h00000000, 30'h3FFFFFFF};
	assign {wr, sz, addr, wmask, wdata} = q;
	core_store i_dut (.CLK(clk), .NRST(nrst), .STRAIGHT_MODE(straight), .TWO_BANKS(two_banks),
		.REQ(req), .ADDR(addr), .WRITE(wr), .SIZE(size_t'(sz)), .WMASK(wmask), .WDATA(wdata),
		.GRANT(grant), .ACK(ack), .RDATA(rdata), .PARITY_INT(par));
	cpu_port_model i_cpu (.clk(clk), .go(go), .f(fld), .grant(grant), .req(req), .q(q));
	// Clock
	initial forever #5 clk = ~clk;
	// Cycle count by NBA so samplers see the pre-edge value
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (nrst && par !== 4'h0) npar <= npar + 1;
		if (cyc == 5000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	function automatic logic [79:0] whole(input logic w, input logic [16:0] a,
		input logic [29:0] d);
		return {w, 2'h0, a, FULL_MASK, d};
	endfunction
	task automatic chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'h1) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	// Bounded wait on grant or on any acknowledge
	task automatic poll(input logic on_ack);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((on_ack ? ack === 4'h0 : grant !== 1'h1) && n < 100);
		if (!on_ack) t_g = grant === 1'h1 ? cyc : -1;
	endtask
	task automatic issue(input logic [79:0] f);
		fld <= f;
		go <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		poll(1'h0);
	endtask
	task automatic wait_ack(input logic [1:0] m, input int tg);
		poll(1'h1);
		chk(ack === 4'h1 << m && cyc - tg == 75, "ack module or time");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Test sequence
	initial begin
		repeat (20) @(posedge clk);
		chk(grant === 1'h0 && ack === 4'h0, "output in reset");
		$display("reset test done");
		nrst <= 1'h1;
		two_banks <= 1'h1;
		repeat (4) @(posedge clk);
		foreach (rows[i]) begin
			straight <= rows[i][19];
			repeat (4) @(posedge clk);
			issue(whole(1'h1, rows[i][18:2], 30'h2AAA0000 + 30'(i)));
			wait_ack(rows[i][1:0], t_g);
			issue(whole(1'h0, rows[i][18:2], 30'h0));
			wait_ack(rows[i][1:0], t_g);
			chk(rdata[30 * rows[i][1:0] +: 30] === 30'h2AAA0000 + 30'(i), "row");
		end
		// One cell seen through both modes
		issue(whole(1'h1, 17'h00001, 30'h1234ABCD));
		wait_ack(2'h0, t_g);
		straight <= 1'h0;
		repeat (4) @(posedge clk);
		issue(whole(1'h0, 17'h00002, 30'h0));
		wait_ack(2'h0, t_g);
		chk(rdata[29:0] === 30'h1234ABCD, "alias");
		$display("map test done");
		// Every size merges into the stored word
		e = '0;
		for (int s = 0; s < 4; s++) begin
			issue({1'h1, 2'(s), 17'h00004, mk[s], dv[s]});
			e = (e & ~mk[s]) | (dv[s] & mk[s]);
			wait_ack(2'h0, t_g);
		end
		issue(whole(1'h0, 17'h00004, 30'h0));
		wait_ack(2'h0, t_g);
		chk(rdata[29:0] === e, "merge");
		$display("size test done");
		// Two modules overlap; a busy module holds off its next request
		issue(whole(1'h0, 17'h00000, 30'h0));
		ta = t_g;
		issue(whole(1'h0, 17'h00001, 30'h0));
		tb = t_g;
		issue(whole(1'h0, 17'h00002, 30'h0));
		chk(tb - ta < 4 && t_g - ta > 75, "overlap");
		wait_ack(2'h1, tb);
		wait_ack(2'h0, t_g);
		// Absent bank waits until the switch brings it in
		two_banks <= 1'h0;
		repeat (4) @(posedge clk);
		issue(whole(1'h0, 17'h10002, 30'h0));
		chk(t_g == -1, "absent bank");
		two_banks <= 1'h1;
		poll(1'h0);
		wait_ack(2'h2, t_g);
		chk(npar == 0, "parity alarm");
		$display("overlap test done");
		tally_and_finish();
	end
endmodule
